// ==== core/stoc_top.sv ====
// Acquisition trigger, sweep stepping, sync output and rear output control.
// Behaviour
// - Output is (value/sens - offset) times expand times 10V.
// - Trigger rate records one sample per rising edge.
// - Trigger-starts option: edge acts as run command.
// - Triggered start also starts frequency and aux sweeps.
// - Internal rate after triggered start ignores later edges.
// - At trigger rate, first edge starts and samples; later edges sample.
// - Sync square wave toggles at oscillator zero crossings.
// - Sync output keeps running with external reference.
// - Power-up loads defaults if backspace held, else saved.
// - Reset command loads defaults, keeps comms and status.
// - Preamp always commanded to maximum gain, uncompensated.
// - Aux sweep steps per sample, pauses, resets to start.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module stoc_top
  import stoc_pkg::*;
#(
  parameter int RATE_DIV_RESET = STOC_RATE_DIV_DEFAULT,
  parameter int CLK_HZ         = STOC_CLK_HZ
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic               external_sample_trigger,
  input  wire logic               acquisition_run_command,
  input  wire logic               backspace_held,
  input  wire logic               powerup_done,
  input  wire logic [3:0]         saved_ctrl,
  input  wire logic               osc_sine_sign,
  input  wire logic signed [15:0] meas_x,
  input  wire logic signed [15:0] meas_y,
  output logic signed [15:0]      x_out_code,
  output logic signed [15:0]      y_out_code,
  output logic                    sync_out,
  output logic                    preamp_max_gain,
  output logic                    sample_strobe,
  output logic                    freq_sweep_start,
  output logic                    freq_sweep_step,
  output logic                    acq_running,
  output logic [15:0]             aux_sweep_value
);

  // Clocks between samples at the ceiling rate, rounded down, so the rate can sit just above the ceiling.
  localparam int RATE_DIV_MIN = CLK_HZ / STOC_MAX_RATE_HZ;

  if (CLK_HZ < STOC_MAX_RATE_HZ || RATE_DIV_RESET < RATE_DIV_MIN)
  begin : g_bad_rate
    $error("Rate divider default exceeds the sampling ceiling.");
  end

  typedef struct packed {
    logic [3:0]   ctrl;
    logic [31:0]  rate_div;
    logic [15:0]  offset;
    logic [8:0]   expand;
    logic [15:0]  sens;
    logic [15:0]  aux_start;
    logic [15:0]  aux_step;
    logic [15:0]  aux_value;
    logic [7:0]   comm;
    stoc_acq_type acq;
    logic [31:0]  rate_cnt;
    logic [31:0]  samples;
    logic         sample;
    logic         fstart;
    logic         fstep;
    logic         sine_s1;
    logic         sine_s2;
    logic         sine_s3;
    logic         sync;
    logic         boot_done;
    logic [31:0]  rdata;
  } stoc_top_type;

  stoc_top_type st_q;
  stoc_top_type st_d;

  logic trig_pulse;
  logic run_pulse;
  logic start_now;
  logic take_sample;
  logic trig_rate;
  logic wr_cmd;

  stoc_edge_sync u_trig_sync (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .pin_in     (external_sample_trigger),
    .rise_pulse (trig_pulse)
  );

  stoc_edge_sync u_run_sync (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .pin_in     (acquisition_run_command),
    .rise_pulse (run_pulse)
  );

  stoc_out_scale u_scale_x (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .meas     (meas_x),
    .sens     (st_q.sens),
    .offset   (st_q.offset),
    .expand   (st_q.expand),
    .out_code (x_out_code)
  );

  stoc_out_scale u_scale_y (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .meas     (meas_y),
    .sens     (st_q.sens),
    .offset   (st_q.offset),
    .expand   (st_q.expand),
    .out_code (y_out_code)
  );

  always_comb
  begin
    st_d = st_q;
    st_d.sample = 1'b0;
    st_d.fstart = 1'b0;
    st_d.fstep = 1'b0;
    trig_rate = st_q.ctrl[STOC_CTRL_TRIG_RATE_BIT];
    wr_cmd = reg_wr && (reg_addr == STOC_REG_CMD);
    start_now = 1'b0;
    take_sample = 1'b0;

    // Power-up recall happens once, when the boot sequence reports done.
    if (!st_q.boot_done && powerup_done)
    begin
      st_d.boot_done = 1'b1;
      st_d.ctrl = backspace_held ? STOC_CTRL_DEFAULT : saved_ctrl;
    end

    // Sync square wave follows the sign of the oscillator sine, whatever the reference.
    st_d.sine_s1 = osc_sine_sign;
    st_d.sine_s2 = st_q.sine_s1;
    st_d.sine_s3 = st_q.sine_s2;
    if (st_q.sine_s2 == st_q.sine_s3)
    begin
      st_d.sync = st_q.sine_s3;
    end

    if (reg_wr)
    begin
      case (reg_addr)
        STOC_REG_CTRL:      st_d.ctrl = reg_wdata[STOC_CTRL_WIDTH-1:0];
        STOC_REG_RATE_DIV:
        begin
          if (reg_wdata >= 32'(RATE_DIV_MIN))
          begin
            st_d.rate_div = reg_wdata;
          end
        end
        STOC_REG_OFFSET:    st_d.offset = reg_wdata[15:0];
        STOC_REG_EXPAND:
        begin
          if (reg_wdata[8:0] != 9'h000 && reg_wdata[8:0] <= 9'h100)
          begin
            st_d.expand = reg_wdata[8:0];
          end
        end
        STOC_REG_SENS:      st_d.sens = reg_wdata[15:0];
        STOC_REG_AUX_START: st_d.aux_start = reg_wdata[15:0];
        STOC_REG_AUX_STEP:  st_d.aux_step = reg_wdata[15:0];
        STOC_REG_COMM:      st_d.comm = reg_wdata[7:0];
        default:            st_d.comm = st_d.comm;
      endcase
    end

    // Defaults on the reset command; comm settings and status counters stay.
    if (wr_cmd && reg_wdata[STOC_CMD_RST_BIT])
    begin
      st_d.ctrl = STOC_CTRL_DEFAULT;
      st_d.rate_div = 32'(RATE_DIV_RESET);
      st_d.offset = STOC_OFFSET_DEFAULT;
      st_d.expand = STOC_EXPAND_DEFAULT;
      st_d.sens = STOC_SENS_DEFAULT;
      st_d.aux_start = STOC_AUX_START_DEFAULT;
      st_d.aux_step = STOC_AUX_STEP_DEFAULT;
    end

    case (st_q.acq)
      STOC_IDLE, STOC_PAUSED:
      begin
        if (run_pulse || (wr_cmd && reg_wdata[STOC_CMD_RUN_BIT]))
        begin
          start_now = 1'b1;
        end
        else if (st_q.ctrl[STOC_CTRL_TRIG_START_BIT])
        begin
          st_d.acq = STOC_ARMED;
        end
      end
      STOC_ARMED:
      begin
        if (trig_pulse || run_pulse || (wr_cmd && reg_wdata[STOC_CMD_RUN_BIT]))
        begin
          start_now = 1'b1;
          take_sample = trig_pulse && trig_rate;
        end
        else if (!st_q.ctrl[STOC_CTRL_TRIG_START_BIT])
        begin
          st_d.acq = STOC_IDLE;
        end
      end
      STOC_RUN:
      begin
        if (trig_rate)
        begin
          take_sample = trig_pulse;
        end
        else if (st_q.rate_cnt + 32'd1 >= st_q.rate_div)
        begin
          take_sample = 1'b1;
        end
        if (wr_cmd && reg_wdata[STOC_CMD_PAUSE_BIT])
        begin
          st_d.acq = STOC_PAUSED;
          take_sample = 1'b0;
        end
      end
      default: st_d.acq = STOC_IDLE;
    endcase

    if (start_now)
    begin
      st_d.acq = STOC_RUN;
      st_d.rate_cnt = '0;
      st_d.fstart = st_q.ctrl[STOC_CTRL_FREQ_SWEEP_BIT];
    end
    else if (st_q.acq == STOC_RUN && !trig_rate)
    begin
      st_d.rate_cnt = take_sample ? 32'd0 : st_q.rate_cnt + 32'd1;
    end

    if (take_sample)
    begin
      st_d.sample = 1'b1;
      st_d.samples = st_q.samples + 32'd1;
      st_d.fstep = st_q.ctrl[STOC_CTRL_FREQ_SWEEP_BIT];
      if (st_q.ctrl[STOC_CTRL_AUX_SWEEP_BIT])
      begin
        st_d.aux_value = st_q.aux_value + st_q.aux_step;
      end
    end

    // Buffer reset stops the scan and returns the aux sweep to its start.
    if (wr_cmd && reg_wdata[STOC_CMD_RESET_BIT])
    begin
      st_d.acq = STOC_IDLE;
      st_d.sample = 1'b0;
      st_d.fstep = 1'b0;
      st_d.samples = '0;
      st_d.rate_cnt = '0;
      st_d.aux_value = st_d.aux_start;
    end

    st_d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        STOC_REG_CTRL:       st_d.rdata = {28'h0, st_q.ctrl};
        STOC_REG_RATE_DIV:   st_d.rdata = st_q.rate_div;
        STOC_REG_OFFSET:     st_d.rdata = {16'h0, st_q.offset};
        STOC_REG_EXPAND:     st_d.rdata = {23'h0, st_q.expand};
        STOC_REG_SENS:       st_d.rdata = {16'h0, st_q.sens};
        STOC_REG_STATUS:     st_d.rdata = {29'h0, st_q.boot_done, 2'(st_q.acq)};
        STOC_REG_SAMPLES:    st_d.rdata = st_q.samples;
        STOC_REG_AUX_START:  st_d.rdata = {16'h0, st_q.aux_start};
        STOC_REG_AUX_STEP:   st_d.rdata = {16'h0, st_q.aux_step};
        STOC_REG_AUX_VALUE:  st_d.rdata = {16'h0, st_q.aux_value};
        STOC_REG_SAVED_CTRL: st_d.rdata = {28'h0, saved_ctrl};
        STOC_REG_COMM:       st_d.rdata = {24'h0, st_q.comm};
        default:             st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.rate_div <= 32'(RATE_DIV_RESET);
      st_q.expand <= STOC_EXPAND_DEFAULT;
      st_q.sens <= STOC_SENS_DEFAULT;
      st_q.aux_start <= STOC_AUX_START_DEFAULT;
      st_q.aux_value <= STOC_AUX_START_DEFAULT;
      st_q.comm <= STOC_COMM_DEFAULT;
      st_q.acq <= STOC_IDLE;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign sync_out = st_q.sync;
  assign preamp_max_gain = 1'b1;
  assign sample_strobe = st_q.sample;
  assign freq_sweep_start = st_q.fstart;
  assign freq_sweep_step = st_q.fstep;
  assign acq_running = (st_q.acq == STOC_RUN);
  assign aux_sweep_value = st_q.aux_value;

endmodule : stoc_top
`default_nettype wire

// ==== core/stoc_pkg.sv ====
// Shared constants and types for the scan trigger and output control block.
package stoc_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] STOC_REG_CTRL       = 4'h0;
  localparam logic [3:0] STOC_REG_RATE_DIV   = 4'h1;
  localparam logic [3:0] STOC_REG_OFFSET     = 4'h2;
  localparam logic [3:0] STOC_REG_EXPAND     = 4'h3;
  localparam logic [3:0] STOC_REG_SENS       = 4'h4;
  localparam logic [3:0] STOC_REG_CMD        = 4'h5;
  localparam logic [3:0] STOC_REG_STATUS     = 4'h6;
  localparam logic [3:0] STOC_REG_SAMPLES    = 4'h7;
  localparam logic [3:0] STOC_REG_AUX_START  = 4'h8;
  localparam logic [3:0] STOC_REG_AUX_STEP   = 4'h9;
  localparam logic [3:0] STOC_REG_AUX_VALUE  = 4'hA;
  localparam logic [3:0] STOC_REG_SAVED_CTRL = 4'hB;
  localparam logic [3:0] STOC_REG_COMM       = 4'hC;

  // Control register fields.
  localparam int STOC_CTRL_TRIG_RATE_BIT   = 0;
  localparam int STOC_CTRL_TRIG_START_BIT  = 1;
  localparam int STOC_CTRL_FREQ_SWEEP_BIT  = 2;
  localparam int STOC_CTRL_AUX_SWEEP_BIT   = 3;
  localparam int STOC_CTRL_WIDTH           = 4;

  // Command register bits, each a one-cycle action.
  localparam int STOC_CMD_RUN_BIT   = 0;
  localparam int STOC_CMD_PAUSE_BIT = 1;
  localparam int STOC_CMD_RESET_BIT = 2;
  localparam int STOC_CMD_RST_BIT   = 3;

  // Reset and default values.
  localparam logic [3:0]  STOC_CTRL_DEFAULT     = 4'h0;
  localparam logic [15:0] STOC_OFFSET_DEFAULT   = 16'h0000;
  localparam logic [8:0]  STOC_EXPAND_DEFAULT   = 9'h001;
  localparam logic [15:0] STOC_SENS_DEFAULT     = 16'h7FFF;
  localparam logic [15:0] STOC_AUX_START_DEFAULT = 16'h03E8;
  localparam logic [15:0] STOC_AUX_STEP_DEFAULT = 16'h0000;
  localparam logic [7:0]  STOC_COMM_DEFAULT     = 8'h08;

  // Timing: the default internal rate is 1 Hz, the ceiling is 512 Hz.
  localparam int STOC_CLK_HZ          = 20000000;
  localparam int STOC_DEFAULT_RATE_HZ = 1;
  localparam int STOC_MAX_RATE_HZ     = 512;
  localparam int STOC_RATE_DIV_DEFAULT = STOC_CLK_HZ / STOC_DEFAULT_RATE_HZ;
  localparam int STOC_RATE_DIV_MIN     = STOC_CLK_HZ / STOC_MAX_RATE_HZ;

  // Full scale of the analog output code, standing for 10 V.
  localparam logic signed [15:0] STOC_FULL_SCALE = 16'sh7FFF;

  typedef enum logic [1:0] {
    STOC_IDLE,
    STOC_ARMED,
    STOC_RUN,
    STOC_PAUSED
  } stoc_acq_type;

endpackage : stoc_pkg

// ==== core/stoc_edge_sync.sv ====
// Three-flop synchroniser and rising-edge pulse for the external trigger pin and the run command pin.
`timescale 1ns/1ps
`default_nettype none
module stoc_edge_sync
  import stoc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin_in,
  output logic      rise_pulse
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } stoc_sync_type;

  stoc_sync_type st_q;
  stoc_sync_type st_d;

  // A change counts once the second and third stages agree; stage one feeds only stage two.
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.level = st_q.s3;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign rise_pulse = ce && st_d.level && !st_q.level;

endmodule : stoc_edge_sync
`default_nettype wire

// ==== core/stoc_out_scale.sv ====
// Registered scaling of one measured channel onto its rear analog output code.
`timescale 1ns/1ps
`default_nettype none
module stoc_out_scale
  import stoc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic signed [15:0] meas,
  input  wire logic        [15:0] sens,
  input  wire logic signed [15:0] offset,
  input  wire logic        [8:0]  expand,
  output logic signed [15:0]      out_code
);

  typedef struct packed {
    logic signed [15:0] code;
  } stoc_scale_type;

  stoc_scale_type st_q;
  stoc_scale_type st_d;

  logic signed [31:0] norm;
  logic signed [31:0] diff;
  logic signed [41:0] prod;
  logic signed [41:0] sat;

  // The measurement is normalised to full scale of the sensitivity, offset
  // (in full-scale units) is removed, then expand multiplies the result.
  always_comb
  begin
    norm = (sens == 16'h0000) ? 32'sh0 :
           ((32'(meas) * 32'(STOC_FULL_SCALE)) / $signed({16'h0000, sens}));
    diff = norm - 32'(offset);
    prod = 42'(diff) * $signed({33'h0, expand});
    if (prod > 42'(STOC_FULL_SCALE))
    begin
      sat = 42'(STOC_FULL_SCALE);
    end
    else if (prod < -42'(STOC_FULL_SCALE))
    begin
      sat = -42'(STOC_FULL_SCALE);
    end
    else
    begin
      sat = prod;
    end
    st_d.code = sat[15:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign out_code = st_q.code;

endmodule : stoc_out_scale
`default_nettype wire

// ==== bench/stoc_top_assertions.sv ====
// Port assertions for the trigger and output control top.
`timescale 1ns/1ps
`default_nettype none
module stoc_top_assertions
  import stoc_pkg::*;
#(parameter int RATE_DIV_RESET = STOC_RATE_DIV_DEFAULT)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        osc_sine_sign,
  input wire logic        sync_out,
  input wire logic        preamp_max_gain,
  input wire logic        sample_strobe,
  input wire logic        freq_sweep_start,
  input wire logic        freq_sweep_step,
  input wire logic        acq_running,
  input wire logic [15:0] aux_sweep_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  gain_held_a: assert property (preamp_max_gain)
    else $error("preamp gain dropped");
  strobe_single_a: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("sample strobe repeated");
  strobe_in_run_a: assert property (sample_strobe |-> acq_running)
    else $error("sample outside a scan");
  sweep_start_a: assert property (freq_sweep_start |-> acq_running && !$past(acq_running))
    else $error("sweep start without scan start");
  sweep_step_a: assert property (freq_sweep_step |-> sample_strobe)
    else $error("sweep step without sample");
  sync_high_a: assert property (osc_sine_sign [*8] |-> sync_out)
    else $error("sync low on positive sine");
  sync_low_a: assert property (!osc_sine_sign [*8] |-> !sync_out)
    else $error("sync high on negative sine");
  sync_edge_a: assert property ($changed(sync_out) |-> sync_out == $past(osc_sine_sign))
    else $error("sync edge against sine sign");
  aux_hold_a: assert property (!acq_running && !reg_wr ##1 !acq_running |-> $stable(aux_sweep_value))
    else $error("aux sweep moved while stopped");
  cover property (freq_sweep_start);
  cover property (sample_strobe && !freq_sweep_step);
  cover property ($fell(acq_running));
endmodule : stoc_top_assertions
bind stoc_top stoc_top_assertions #(.RATE_DIV_RESET(RATE_DIV_RESET)) chk_i (
  .clk, .rst, .reg_wr, .osc_sine_sign, .sync_out, .preamp_max_gain, .sample_strobe,
  .freq_sweep_start, .freq_sweep_step, .acq_running, .aux_sweep_value);
`default_nettype wire

// ==== bench/stoc_trig_source.sv ====
// External trigger source model driving the trigger pin.
`timescale 1ns/1ps
`default_nettype none
module stoc_trig_source
  import stoc_pkg::*;
#(parameter int GAP = STOC_RATE_DIV_MIN, parameter int HIGH = 20)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fire,
  output logic      pin,
  output logic      busy
);
  int cnt;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      pin <= 1'b0;
    end
    else if (cnt != 0)
    begin
      cnt <= cnt - 1;
      pin <= (cnt > GAP - HIGH);
    end
    else if (fire)
    begin
      cnt <= GAP;
      pin <= 1'b1;
    end
  end
  assign busy = (cnt != 0);
endmodule : stoc_trig_source
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the trigger and output control top.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import stoc_pkg::*;
;
  localparam int SIM_HZ = 1000000;
  localparam int GAP    = SIM_HZ / STOC_MAX_RATE_HZ;
  logic               clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic               run_key = 1'b0, bs = 1'b0, pwr = 1'b0, osc = 1'b0, fire = 1'b0;
  logic               trig, busy, sync, gain, strobe, fs_start, fs_step, running;
  logic [3:0]         reg_addr = 4'h0, saved = 4'h0;
  logic [31:0]        reg_wdata = 32'h0, reg_rdata;
  logic signed [15:0] mx = 16'sh0, my = 16'sh0, xo, yo;
  logic [15:0]        aux;
  int                 n_errors = 0, checked = 0, cyc = 0, n_str = 0, n_fs = 0;
  int                 seed = 91507, m_str, m_aux, a, b, o, e;

  stoc_top #(.RATE_DIV_RESET(GAP), .CLK_HZ(SIM_HZ)) uut (
    .clk, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .external_sample_trigger(trig), .acquisition_run_command(run_key),
    .backspace_held(bs), .powerup_done(pwr), .saved_ctrl(saved), .osc_sine_sign(osc),
    .meas_x(mx), .meas_y(my), .x_out_code(xo), .y_out_code(yo), .sync_out(sync),
    .preamp_max_gain(gain), .sample_strobe(strobe), .freq_sweep_start(fs_start),
    .freq_sweep_step(fs_step), .acq_running(running), .aux_sweep_value(aux));
  // The block assumes a slower clock, so the 512 Hz trigger spacing fits a short run.
  stoc_trig_source #(.GAP(GAP)) src (.clk, .rst, .fire, .pin(trig), .busy);

  always #25 clk = ~clk;

  function automatic int nxt(input int s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic int sat(input int v);
    return (v > 32767) ? 32767 : v;
  endfunction : sat

  task automatic conclude();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  task automatic boot(input logic hold, input logic [3:0] s);
    rst <= 1'b1;
    pwr <= 1'b0;
    bs <= hold;
    saved <= s;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    pwr <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : boot

  task automatic pulse();
    @(posedge clk);
    while (busy) @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_str <= n_str + int'(strobe);
    n_fs <= n_fs + int'(fs_start);
    if (cyc > 200 && cyc % 40 == 0)
      chk({31'h0, sync}, {31'h0, osc});
    if (cyc % 40 == 0)
      osc <= ~osc;
    if (cyc == 20 * GAP)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    boot(1'b0, 4'h6);
    rd(STOC_REG_CTRL, 32'h6);
    boot(1'b1, 4'h6);
    rd(STOC_REG_CTRL, 32'h0);
    $display("end power-up");
    rd(4'hF, 32'h0);
    wr(STOC_REG_RATE_DIV, 32'd100);
    wr(STOC_REG_STATUS, 32'h3);
    rd(STOC_REG_RATE_DIV, GAP);
    wr(STOC_REG_EXPAND, 32'h3);
    wr(STOC_REG_EXPAND, 32'h0);
    wr(STOC_REG_EXPAND, 32'd257);
    rd(STOC_REG_EXPAND, 32'h3);
    wr(STOC_REG_COMM, 32'h55);
    wr(STOC_REG_CMD, 32'h8);
    rd(STOC_REG_EXPAND, 32'h1);
    rd(STOC_REG_SENS, 32'h7FFF);
    rd(STOC_REG_COMM, 32'h55);
    $display("end registers");
    pulse();
    chk(n_str, 0);
    rd(STOC_REG_STATUS, 32'h4);
    $display("end idle trigger");
    for (int i = 0; i < 6; i++)
    begin
      seed = nxt(seed);
      e = (i == 5) ? 256 : int'(seed[3:0]) + 1;
      o = (i == 5) ? 0 : int'(seed[11:4]);
      a = (i == 5) ? 300 : int'(seed[25:16]) - 512;
      b = (i == 5) ? -50 : int'(seed[31:22]) - 512;
      wr(STOC_REG_OFFSET, o);
      wr(STOC_REG_EXPAND, e);
      mx <= 16'(a);
      my <= 16'(b);
      repeat (8) @(posedge clk);
      chk(xo, sat((a - o) * e));
      chk(yo, sat((b - o) * e));
    end
    $display("end scaling");
    wr(STOC_REG_AUX_STEP, 32'h10);
    wr(STOC_REG_CTRL, 32'hF);
    rd(STOC_REG_STATUS, 32'h5);
    m_aux = 'h3E8;
    for (int k = 1; k <= 2; k++)
    begin
      pulse();
      m_aux += 'h10;
      chk(n_str, k);
      chk(aux, m_aux);
    end
    chk(n_fs, 1);
    rd(STOC_REG_SAMPLES, 32'h2);
    wr(STOC_REG_CMD, 32'h2);
    repeat (3) @(posedge clk);
    chk(running, 1'b0);
    rd(STOC_REG_STATUS, 32'h5);
    @(posedge clk);
    run_key <= 1'b1;
    repeat (8) @(posedge clk);
    run_key <= 1'b0;
    chk(running, 1'b1);
    wr(STOC_REG_CMD, 32'h4);
    repeat (3) @(posedge clk);
    chk(aux, 32'h3E8);
    rd(STOC_REG_SAMPLES, 32'h0);
    wr(STOC_REG_CMD, 32'h2);
    $display("end triggered scan");
    wr(STOC_REG_CTRL, 32'h2);
    pulse();
    chk(running, 1'b1);
    m_str = n_str;
    for (int w = 0; w < 2 * GAP && n_str == m_str; w++)
      @(posedge clk);
    chk(n_str, m_str + 1);
    // A long internal period keeps the next timed sample out of the two trigger gaps.
    wr(STOC_REG_RATE_DIV, 8 * GAP);
    m_str = n_str;
    pulse();
    pulse();
    chk(n_str, m_str);
    $display("end internal rate");
    conclude();
  end
endmodule : testbench
`default_nettype wire
